// ===== design/blcc_pkg.sv
// Constants for the black level calibration control register.
// Assumes a word-wide register write/read port inside the sensor.
package blcc_pkg;
	localparam logic [7:0] REG_OFFSET = 8'h62;
	localparam int BIT_NO_SWEEP = 15;
	localparam int BIT_RESTART = 12;
	localparam int BIT_KEEP_HI = 11;
	localparam int BIT_MODE_HI = 2;
	localparam int BIT_MODE_LO = 1;
	localparam int BIT_MANUAL = 0;
	localparam logic [15:0] RESET_VALUE = 16'h07F8;
	// Bits held in storage; bit 12 is a pulse and never stored.
	localparam logic [15:0] STORE_MASK = 16'hEFFF;
	localparam logic [7:0] THRESH_STEP = 8'h05;
endpackage

// ===== design/blcc_ctrl.sv
// Black level calibration control register and its decoded controls.
// Assumes a synchronous, word-wide register port from the serial access logic.
//
// Functional notes
// - Bit 15 set skips the rapid sweep after a gain change.
// - Writing one to bit 12 restarts the filtered average and starts a rapid sweep.
// - Bit 12 clears itself right after being written with one.
// - Bit 11 clear resets the upper threshold after a sweep, set keeps it.
// - Mode 00 applies calibration only while the converter runs.
// - Mode 10 applies calibration continuously.
// - Mode low bit set disables correction, forcing offset and skew to zero.
// - Bit 0 set uses programmed correction values instead of the derived ones.
// - The reset upper threshold is the lower threshold plus five.
`timescale 1ns/10ps
module blcc_ctrl (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	// Calibration events
	input wire logic gain_change_i,
	input wire logic sweep_done_i,
	input wire logic adc_active_i,
	input wire logic [7:0] lower_black_threshold_i,
	input wire logic [7:0] auto_offset_i,
	input wire logic [7:0] auto_skew_i,
	input wire logic [7:0] prog_offset_i,
	input wire logic [7:0] prog_skew_i,
	// Calibration controls
	output logic restart_avg_o,
	output logic sweep_start_o,
	output logic cal_apply_o,
	output logic [7:0] offset_o,
	output logic [7:0] skew_o,
	output logic upper_thresh_load_o,
	output logic [7:0] upper_black_threshold_o
);
	logic [15:0] ctrl_r, ctrl_nxt;
	logic restart_r, restart_nxt;
	logic sweep_r, sweep_nxt;
	logic load_r, load_nxt;
	logic [7:0] upper_r, upper_nxt;
	logic [7:0] offset_r, offset_nxt;
	logic [7:0] skew_r, skew_nxt;
	logic apply_r, apply_nxt;
	logic wr_hit;

	// ------------------------------------------------------------------
	// Register storage and event pulses
	// ------------------------------------------------------------------
	assign wr_hit = reg_wr_i && (reg_addr_i == blcc_pkg::REG_OFFSET);

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_hit) begin
			ctrl_nxt = reg_wdata_i & blcc_pkg::STORE_MASK;
		end
		restart_nxt = wr_hit && reg_wdata_i[blcc_pkg::BIT_RESTART];
		sweep_nxt = restart_nxt || (gain_change_i && !ctrl_r[blcc_pkg::BIT_NO_SWEEP]);
		// The upper threshold is refreshed only when bit 11 is clear.
		// The sum wraps at eight bits, so a lower threshold near the top of its range gives a small upper one.
		load_nxt = sweep_done_i && !ctrl_r[blcc_pkg::BIT_KEEP_HI];
		upper_nxt = load_nxt ? lower_black_threshold_i + blcc_pkg::THRESH_STEP : upper_r;
	end

	// ------------------------------------------------------------------
	// Correction selection
	// ------------------------------------------------------------------
	always_comb begin
		if (ctrl_r[blcc_pkg::BIT_MODE_LO]) begin
			apply_nxt = 1'b0;
			offset_nxt = 8'h00;
			skew_nxt = 8'h00;
		end else begin
			// Mode 10 runs always, mode 00 only during conversion.
			apply_nxt = ctrl_r[blcc_pkg::BIT_MODE_HI] || adc_active_i;
			offset_nxt = ctrl_r[blcc_pkg::BIT_MANUAL] ? prog_offset_i : auto_offset_i;
			skew_nxt = ctrl_r[blcc_pkg::BIT_MANUAL] ? prog_skew_i : auto_skew_i;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Reset ignores the enable so that a stopped enable cannot trap the register in an old value.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ctrl_r <= blcc_pkg::RESET_VALUE;
			restart_r <= 1'b0;
			sweep_r <= 1'b0;
			load_r <= 1'b0;
			upper_r <= 8'h00;
		end else if (ce_i) begin
			ctrl_r <= ctrl_nxt;
			restart_r <= restart_nxt;
			sweep_r <= sweep_nxt;
			load_r <= load_nxt;
			upper_r <= upper_nxt;
		end
	end

	// The correction path costs a cycle so the analog drivers see one clean change per mode rewrite.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			offset_r <= 8'h00;
			skew_r <= 8'h00;
			apply_r <= 1'b0;
		end else if (ce_i) begin
			offset_r <= offset_nxt;
			skew_r <= skew_nxt;
			apply_r <= apply_nxt;
		end
	end

	// Reads are decoded so any other address returns zero.
	assign reg_rdata_o = (reg_addr_i == blcc_pkg::REG_OFFSET) ? ctrl_r : 16'h0000;
	assign restart_avg_o = restart_r;
	assign sweep_start_o = sweep_r;
	assign cal_apply_o = apply_r;
	assign offset_o = offset_r;
	assign skew_o = skew_r;
	assign upper_thresh_load_o = load_r;
	assign upper_black_threshold_o = upper_r;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	// Reset sets the reserved fields to their fixed pattern and leaves no pulse behind.
	property p_reset;
		@(posedge clk_i)
		!rst_n_i |=> ctrl_r == blcc_pkg::RESET_VALUE && !sweep_start_o && !restart_avg_o
			&& !upper_thresh_load_o;
	endproperty
	a_reset: assert property (p_reset) else $error("reset value wrong");

	property p_restart;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && wr_hit && reg_wdata_i[blcc_pkg::BIT_RESTART]) |=> (restart_avg_o && sweep_start_o);
	endproperty
	a_restart: assert property (p_restart) else $error("restart not pulsed");

	// Without a fresh request the restart pulse must drop at the next enabled edge.
	property p_restart_once;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && restart_avg_o && !(wr_hit && reg_wdata_i[blcc_pkg::BIT_RESTART])) |=> !restart_avg_o;
	endproperty
	a_restart_once: assert property (p_restart_once) else $error("restart pulse held");

	property p_selfclr;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && wr_hit) |=> !reg_rdata_o[blcc_pkg::BIT_RESTART] && !ctrl_r[blcc_pkg::BIT_RESTART];
	endproperty
	a_selfclr: assert property (p_selfclr) else $error("restart bit stored");

	property p_sweep_gain;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && gain_change_i && !ctrl_r[blcc_pkg::BIT_NO_SWEEP]) |=> sweep_start_o;
	endproperty
	a_sweep_gain: assert property (p_sweep_gain) else $error("gain sweep missing");

	property p_nosweep;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && gain_change_i && ctrl_r[blcc_pkg::BIT_NO_SWEEP] && !wr_hit) |=> !sweep_start_o;
	endproperty
	a_nosweep: assert property (p_nosweep) else $error("sweep not skipped");

	property p_keep;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && ctrl_r[blcc_pkg::BIT_KEEP_HI]) |=> !upper_thresh_load_o && $stable(upper_black_threshold_o);
	endproperty
	a_keep: assert property (p_keep) else $error("threshold changed");

	property p_load_cause;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !sweep_done_i) |=> !upper_thresh_load_o;
	endproperty
	a_load_cause: assert property (p_load_cause) else $error("threshold load without sweep");

	property p_thresh;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && sweep_done_i && !ctrl_r[blcc_pkg::BIT_KEEP_HI])
			|=> upper_thresh_load_o
			&& upper_black_threshold_o == 8'($past(lower_black_threshold_i) + blcc_pkg::THRESH_STEP);
	endproperty
	a_thresh: assert property (p_thresh) else $error("threshold not low plus five");

	property p_mode00;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !ctrl_r[blcc_pkg::BIT_MODE_HI] && !ctrl_r[blcc_pkg::BIT_MODE_LO])
			|=> cal_apply_o == $past(adc_active_i);
	endproperty
	a_mode00: assert property (p_mode00) else $error("mode 00 wrong");

	property p_mode10;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && ctrl_r[blcc_pkg::BIT_MODE_HI] && !ctrl_r[blcc_pkg::BIT_MODE_LO]) |=> cal_apply_o;
	endproperty
	a_mode10: assert property (p_mode10) else $error("mode 10 wrong");

	property p_disable;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && ctrl_r[blcc_pkg::BIT_MODE_LO]) |=> (offset_o == 8'h00 && skew_o == 8'h00 && !cal_apply_o);
	endproperty
	a_disable: assert property (p_disable) else $error("correction not zero");

	property p_manual;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && ctrl_r[blcc_pkg::BIT_MANUAL] && !ctrl_r[blcc_pkg::BIT_MODE_LO])
			|=> offset_o == $past(prog_offset_i) && skew_o == $past(prog_skew_i);
	endproperty
	a_manual: assert property (p_manual) else $error("manual value not used");

	property p_auto;
		@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && !ctrl_r[blcc_pkg::BIT_MANUAL] && !ctrl_r[blcc_pkg::BIT_MODE_LO])
			|=> offset_o == $past(auto_offset_i) && skew_o == $past(auto_skew_i);
	endproperty
	a_auto: assert property (p_auto) else $error("derived value not used");

	// A low enable must hold the control word, upper threshold, restart pulse, apply flag and offset.
	property p_freeze;
		@(posedge clk_i) disable iff (!rst_n_i)
		!ce_i |=> $stable(ctrl_r) && $stable(upper_black_threshold_o) && $stable(restart_avg_o)
			&& $stable(cal_apply_o) && $stable(offset_o);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule

// ===== tb/test_blcc_ctrl.sv
// Self-checking bench for the black level calibration control register.
// Assumes blcc_pkg and blcc_ctrl are compiled first; the bench drives every port.
`timescale 1ns/10ps
module test_blcc_ctrl;
	typedef struct {logic [15:0] r; logic [1:0] pl; logic ld, ap; logic [7:0] th; logic [15:0] cor;} blcc_note_t;
	logic clk = 1'b0;
	logic ce = 1'b1;
	logic rst_n = 1'b0;
	logic wr = 1'b0, gain = 1'b0, done = 1'b0, adc = 1'b0;
	logic [7:0] addr = 8'h62;
	logic [7:0] cv [5] = '{default: 8'h00};
	logic [15:0] wd = 16'h0000;
	logic [15:0] m = 16'h07F8;
	logic [7:0] mth = 8'h00;
	logic [31:0] seed = 32'hF7D3131E;
	wire [15:0] rdata;
	wire [7:0] off_o, skw_o, th_o;
	wire rs_o, sw_o, ap_o, ld_o;
	int error_cnt = 0, comparisons = 0;
	blcc_note_t q[$];
	blcc_note_t prev;
	always #5 clk = ~clk;
	blcc_ctrl u_blcc_ctrl (.clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .reg_addr_i(addr), .reg_wr_i(wr),
		.reg_wdata_i(wd), .reg_rdata_o(rdata), .gain_change_i(gain), .sweep_done_i(done), .adc_active_i(adc),
		.lower_black_threshold_i(cv[0]), .auto_offset_i(cv[1]), .auto_skew_i(cv[2]), .prog_offset_i(cv[3]),
		.prog_skew_i(cv[4]), .restart_avg_o(rs_o), .sweep_start_o(sw_o), .cal_apply_o(ap_o), .offset_o(off_o),
		.skew_o(skw_o), .upper_thresh_load_o(ld_o), .upper_black_threshold_o(th_o));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Driver and monitor
	// ----------------------------------------
	// Gain and sweep events stay off write cycles so that each pulse has a single cause.
	task automatic step(input int i);
		blcc_note_t n;
		logic hit;
		@(posedge clk);
		#1;
		seed = lfsr(seed);
		rst_n = 1'b1;
		ce = i < 8 || seed[12:10] != 3'h0;
		wr = i < 8 || seed[3:0] == 4'h0;
		addr = (i >= 8 && seed[6:4] == 3'h0) ? 8'h20 : 8'h62;
		wd = 16'h07F8 | (i < 8 ? 16'(i) : seed[31:16] & 16'h9807);
		gain = !wr && seed[7];
		done = !wr && seed[8];
		adc = seed[9];
		for (int k = 0; k < 5; k++) cv[k] = seed[8 * (k % 4) +: 8] ^ 8'(k);
		hit = ce && wr && addr == 8'h62;
		// A disabled edge changes nothing, so the outputs keep the previous note.
		n = prev;
		if (ce) begin
			n.pl = {hit && wd[12], (hit && wd[12]) || (gain && !m[15])};
			n.ld = done && !m[11];
			if (n.ld) mth = cv[0] + 8'h05;
			n.th = mth;
			n.ap = !m[1] && (m[2] || adc);
			n.cor = m[1] ? 16'h0000 : (m[0] ? {cv[3], cv[4]} : {cv[1], cv[2]});
		end
		if (hit) m = wd & blcc_pkg::STORE_MASK;
		n.r = m;
		prev = n;
		q.push_back(n);
	endtask
	always @(posedge clk) begin
		blcc_note_t n;
		int due;
		// Only a note queued before this edge is answered by it; the driver adds the next note after the edge.
		due = q.size();
		#2;
		if (due > 0) begin
			n = q.pop_front();
			check(rdata, addr == 8'h62 ? n.r : 16'h0000);
			check({rs_o, sw_o}, n.pl);
			check({ld_o, th_o}, {n.ld, n.th});
			check(ap_o, n.ap);
			check({off_o, skw_o}, n.cor);
		end
	end
	initial begin
		repeat (7) @(posedge clk);
		for (int i = 0; i < 400; i++) step(i);
		for (int t = 0; t < 5 && q.size() > 0; t++) @(posedge clk);
		#3;
		if (q.size() > 0) error_cnt++;
		end_sim();
	end
endmodule
